// ==== dv/rsc_pin_driver.sv ====
// External reset supervisor model driving the active-low reset pin.
// Assumes a pull-up on the pin and one clock shared with the bench.
module rsc_pin_driver #(
  parameter int HOLD = 250
) (
  input wire logic clk,
  input wire logic go,
  output logic reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = HOLD;
  // Pin low from power-up and for HOLD cycles after each go pulse that arrives while the pin is high
  always @(posedge clk)
  begin
    if (go && cnt == 0)
      cnt <= HOLD;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign reset_pin_n = (cnt == 0);
endmodule : rsc_pin_driver

// ==== dv/rsc_reset_source_controller_props.sv ====
// Checker for the reset source controller outputs.
// Assumes it is bound to the top module and sees only its ports.
module rsc_reset_source_controller_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic supply_above_threshold,
  input wire logic watchdog_underflow,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic internal_reset_n,
  input wire logic fetch_reset_vector,
  input wire logic [1:0] cpu_clock_sel,
  input wire logic ram_write_block,
  input wire rsc_pkg::rsc_opt_s options
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Reset, release and read data relations
  chk_ram_guard: assert property (ram_write_block == !internal_reset_n)
  else $error("ram block differs from reset");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
  else $error("read data without read");
  chk_pin_hold: assert property ((!reset_pin_n)[*6] |-> !internal_reset_n)
  else $error("pin low but not in reset");
  chk_wd_reset: assert property (watchdog_underflow |-> ##[1:3] !internal_reset_n)
  else $error("underflow gave no reset");
  chk_por_hold: assert property
    ((options.monitor0_enable && !supply_above_threshold)[*6] |-> !internal_reset_n)
  else $error("low supply but not in reset");
  chk_fetch_rel: assert property ($rose(internal_reset_n) |-> ##[0:1] fetch_reset_vector)
  else $error("no vector fetch at release");
  chk_fetch_once: assert property (fetch_reset_vector |=> !fetch_reset_vector)
  else $error("vector fetch too long");
  chk_clk_sel: assert property
    ($rose(internal_reset_n) |-> cpu_clock_sel == rsc_pkg::CLK_LOCO_UNDIV)
  else $error("wrong clock after reset");
  chk_seq_len: assert property ($rose(internal_reset_n) |-> !$past(internal_reset_n, 4))
  else $error("reset sequence too short");
endmodule : rsc_reset_source_controller_props
bind rsc_reset_source_controller rsc_reset_source_controller_props u_props (.clk, .nrst,
  .reset_pin_n, .supply_above_threshold, .watchdog_underflow, .rd, .rdata, .internal_reset_n,
  .fetch_reset_vector, .cpu_clock_sel, .ram_write_block, .options);

// ==== dv/rsc_reset_source_controller_tb.sv ====
// Testbench for the reset source controller.
// Assumes a 40 ns clock and the pin driver model on the reset pin.
module rsc_reset_source_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, sup = 1, osc = 0, wd = 0, wr = 0, rd = 0, go = 0;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic irst_n, fetch, ramb, pin_n;
  logic [1:0] csel;
  rsc_pkg::rsc_opt_s opt;
  int bad_count = 0, compares = 0;
  logic [13:0] per [4] = '{14'h03ff, 14'h0fff, 14'h1fff, 14'h3fff};
  rsc_reset_source_controller dut (.clk(clk), .nrst(nrst), .reset_pin_n(pin_n),
    .supply_above_threshold(sup), .slow_osc(osc), .watchdog_underflow(wd), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .internal_reset_n(irst_n),
    .fetch_reset_vector(fetch), .cpu_clock_sel(csel), .ram_write_block(ramb), .options(opt));
  rsc_pin_driver #(.HOLD(250)) u_pin (.clk(clk), .go(go), .reset_pin_n(pin_n));
  // Clock and watchdog
  initial forever #20 clk = ~clk;
  initial
  begin
    #800000;
    bad_count++;
    end_of_test();
  end
  task end_of_test();
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(string n, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      $display("BAD %s exp %h saw %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task put(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : put
  task get(string n, logic [15:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(n, e, rdata & m);
  endtask : get
  task lvl(logic v, int n);
    #1;
    for (int i = 0; i < n && irst_n !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irst_n", v, irst_n);
  endtask : lvl
  task pulse_osc(int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk);
      osc <= 1;
      repeat (4) @(posedge clk);
      osc <= 0;
    end
  endtask : pulse_osc
  task s_boot();
    repeat (100) @(posedge clk);
    #1 chk("boot hold", 0, irst_n);
    lvl(1, 400);
    get("unmapped", 16'h0100, 8'hff, 8'h00);
  endtask : s_boot
  task s_opt();
    for (int i = 0; i < 4; i++)
    begin
      put(rsc_pkg::WATCHDOG_OPTION_BYTE_ADDR, {4'hf, 2'(3 - i), 2'(i)});
      repeat (2) @(posedge clk);
      #1 chk("period", per[i], opt.wd_period);
      chk("window", 3 - i, opt.wd_window_sel);
    end
    for (int j = 0; j < 4; j++)
    begin
      put(rsc_pkg::BOOT_OPTION_BYTE_ADDR, {j[1], 1'b1, 2'(j), 2'(j), 1'b1, j[0]});
      repeat (2) @(posedge clk);
      #1 chk("boot", {j[0], j == 1, 2'(j), 1'b0, !j[1]},
        {opt.wd_stopped, opt.code_protect, opt.threshold_sel, opt.monitor0_enable,
        opt.count_src_protect});
    end
  endtask : s_opt
  task s_cold();
    nrst <= 0;
    repeat (8) @(posedge clk);
    nrst <= 1;
    lvl(1, 50);
    put(rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0e);
    get("flags ro", rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0f, 8'h00);
    put(rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h01);
    get("cold set", rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0f, 8'h01);
  endtask : s_cold
  task s_pin();
    go <= 1;
    @(posedge clk);
    go <= 0;
    lvl(0, 20);
    repeat (100) @(posedge clk);
    #1 chk("pin hold", 0, irst_n);
    lvl(1, 400);
    get("pin flag", rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0f, 8'h03);
  endtask : s_pin
  task s_soft();
    put(rsc_pkg::PROCESSOR_MODE_REG0_ADDR, 8'h08);
    repeat (6) @(posedge clk);
    #1 chk("locked", 1, irst_n);
    put(rsc_pkg::PROTECT_CONTROL_REG_ADDR, 8'h02);
    put(rsc_pkg::PROCESSOR_MODE_REG0_ADDR, 8'h08);
    lvl(0, 10);
    lvl(1, 20);
    get("soft flag", rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0f, 8'h07);
  endtask : s_soft
  task s_wd();
    wd <= 1;
    @(posedge clk);
    wd <= 0;
    lvl(0, 10);
    lvl(1, 20);
    get("wd flag", rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0f, 8'h0f);
  endtask : s_wd
  task s_por();
    put(rsc_pkg::BOOT_OPTION_BYTE_ADDR, 8'hbf);
    repeat (2) @(posedge clk);
    #1 chk("mon0 en", 1, opt.monitor0_enable);
    sup <= 0;
    lvl(0, 10);
    sup <= 1;
    pulse_osc(31);
    repeat (6) @(posedge clk);
    #1 chk("por count", 0, irst_n);
    pulse_osc(1);
    lvl(1, 30);
    chk("clk sel", 0, csel);
    get("cold clr", rsc_pkg::RESET_CAUSE_FLAGS_ADDR, 8'h0f, 8'h0e);
  endtask : s_por
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    s_boot();
    s_opt();
    s_cold();
    s_pin();
    s_soft();
    s_wd();
    s_por();
    end_of_test();
  end
endmodule : rsc_reset_source_controller_tb

// ==== hw/rsc_pkg.sv ====
// Package for the reset source controller: offsets, field positions, timing.
// Assumes a 25 MHz system clock and an 8-bit register port.
package rsc_pkg;
  localparam logic [15:0] RESET_CAUSE_FLAGS_ADDR = 16'h000b;
  localparam logic [15:0] PROCESSOR_MODE_REG0_ADDR = 16'h0004;
  localparam logic [15:0] PROTECT_CONTROL_REG_ADDR = 16'h000a;
  localparam logic [15:0] CLOCK_SEL_ADDR = 16'h0006;
  localparam logic [15:0] WATCHDOG_OPTION_BYTE_ADDR = 16'hffdb;
  localparam logic [15:0] BOOT_OPTION_BYTE_ADDR = 16'hffff;
  localparam int COLD_WARM_BIT = 0;
  localparam int PIN_SEEN_BIT = 1;
  localparam int SOFT_SEEN_BIT = 2;
  localparam int WD_SEEN_BIT = 3;
  localparam int SOFT_REQ_BIT = 3;
  localparam int UNLOCK_BIT = 1;
  localparam int AUTOSTART_N_BIT = 0;
  localparam int PROTECT_DIS_BIT = 2;
  localparam int PROTECT_SEL_BIT = 3;
  localparam int THR_LO_BIT = 4;
  localparam int MON0_START_N_BIT = 6;
  localparam int CSP_N_BIT = 7;
  localparam int WD_PERIOD_LO_BIT = 0;
  localparam int WD_WINDOW_LO_BIT = 2;
  localparam logic [7:0] OPTION_ERASED = 8'hff;
  localparam logic [5:0] POR_COUNT = 6'h20;
  localparam logic [13:0] WD_PERIOD_0 = 14'h03ff;
  localparam logic [13:0] WD_PERIOD_1 = 14'h0fff;
  localparam logic [13:0] WD_PERIOD_2 = 14'h1fff;
  localparam logic [13:0] WD_PERIOD_3 = 14'h3fff;
  localparam logic [1:0] CLK_LOCO_UNDIV = 2'h0;
  localparam int SEQ_CYCLES = 4;
  // Threshold codes: 0=3.80 V, 1=2.85 V, 2=2.35 V, 3=1.90 V
  typedef struct packed {
    logic wd_stopped;
    logic code_protect;
    logic [1:0] threshold_sel;
    logic monitor0_enable;
    logic count_src_protect;
    logic [13:0] wd_period;
    logic [1:0] wd_window_sel;
  } rsc_opt_s;
  typedef enum logic [1:0] {
    RSC_HOLD = 2'b00,
    RSC_POR_WAIT = 2'b01,
    RSC_SEQ = 2'b10,
    RSC_RUN = 2'b11
  } rsc_state_e;
endpackage : rsc_pkg

// ==== hw/rsc_reset_source_controller.sv ====
// Reset source controller: combines reset sources and keeps cause flags.
// Assumes pin, supply and oscillator inputs are asynchronous to clk;
// watchdog underflow comes from logic on clk.
// Behaviour
// RL1: Low reset pin holds chip in reset
// RL2: Soft request bit write resets the chip
// RL3: Watchdog underflow resets the chip
// RL4: Pin release starts fetch from reset vector
// RL5: Reset selects undivided low-speed oscillator clock
// RL6: RAM is never cleared by reset
// RL7: Outside holds pin low ten microseconds
// RL8: Outside waits supply settle plus ten microseconds
// RL9: Thirty-two slow clocks after threshold, release
// RL10: Power-on reset only when monitor0 enabled
// RL11: Cold flag clears on power/monitor reset
// RL12: Writing one sets cold flag; zero ignored
// RL13: Cold flag undefined when monitor disabled
// RL14: Read-only detect flags at bits one-three
// RL15: Software unlocks before writing mode register
// RL16: Option bit0 selects watchdog autostart
// RL17: Code protect from disable and select bits
// RL18: Option bits five-four select threshold
// RL19: Option bit six enables monitor0 reset
// RL20: Option bit seven enables count protect
// RL21: Second option bits set watchdog period
// RL22: Second option bits set refresh window
// RL23: Each reset sets its own detect flag
// RL24: Internal reset ORs sources, common sequence
module rsc_reset_source_controller (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic supply_above_threshold,
  input wire logic slow_osc,
  input wire logic watchdog_underflow,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic internal_reset_n,
  output logic fetch_reset_vector,
  output logic [1:0] cpu_clock_sel,
  output logic ram_write_block,
  output rsc_pkg::rsc_opt_s options
);
  logic [1:0] pin_sync_reg;
  logic [1:0] sup_sync_reg;
  logic [2:0] osc_sync_reg;
  logic pin_low;
  logic supply_ok;
  logic osc_edge;
  logic [7:0] boot_opt_reg;
  logic [7:0] wd_opt_reg;
  logic cold_warm_reg;
  logic pin_seen_reg;
  logic soft_seen_reg;
  logic wd_seen_reg;
  logic unlock_reg;
  logic soft_req_reg;
  logic wd_req_reg;
  logic [1:0] clk_sel_reg;
  logic [5:0] por_cnt_reg;
  logic [2:0] seq_cnt_reg;
  logic por_pending_reg;
  rsc_pkg::rsc_state_e state_reg;
  rsc_pkg::rsc_state_e state_next;
  logic mon0_en;
  logic any_src;
  logic power_src;
  logic mode_wr;

  // Two-stage synchronisers; edge detect reads stages two and three only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      // Pin stages start at the idle high level, so no false pin reset
      pin_sync_reg <= 2'h3;
      sup_sync_reg <= 2'h0;
      osc_sync_reg <= 3'h0;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[0], reset_pin_n};
      sup_sync_reg <= {sup_sync_reg[0], supply_above_threshold};
      osc_sync_reg <= {osc_sync_reg[1:0], slow_osc};
    end
  end

  assign pin_low = !pin_sync_reg[1];
  assign supply_ok = sup_sync_reg[1];
  assign osc_edge = osc_sync_reg[1] && !osc_sync_reg[2];
  assign mon0_en = !boot_opt_reg[rsc_pkg::MON0_START_N_BIT]; // RL19
  // Power-on / monitor0 source only acts when monitor0 is enabled
  assign power_src = mon0_en && !supply_ok; // RL10
  // Any active source holds the internal reset
  assign any_src = pin_low || power_src || soft_req_reg || wd_req_reg; // RL24
  assign mode_wr = wr && (addr == rsc_pkg::PROCESSOR_MODE_REG0_ADDR) && unlock_reg;

  // Option bytes; flash image, erased value after chip reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      boot_opt_reg <= rsc_pkg::OPTION_ERASED;
      wd_opt_reg <= rsc_pkg::OPTION_ERASED;
    end
    else
    begin
      if (wr && addr == rsc_pkg::BOOT_OPTION_BYTE_ADDR)
        boot_opt_reg <= wdata;
      if (wr && addr == rsc_pkg::WATCHDOG_OPTION_BYTE_ADDR)
        wd_opt_reg <= wdata;
    end
  end

  // Decoded option fields
  always_comb
  begin
    options.wd_stopped = boot_opt_reg[rsc_pkg::AUTOSTART_N_BIT]; // RL16
    options.code_protect = boot_opt_reg[rsc_pkg::PROTECT_DIS_BIT]
      && !boot_opt_reg[rsc_pkg::PROTECT_SEL_BIT]; // RL17
    options.threshold_sel = boot_opt_reg[rsc_pkg::THR_LO_BIT +: 2]; // RL18
    options.monitor0_enable = mon0_en; // RL19
    options.count_src_protect = !boot_opt_reg[rsc_pkg::CSP_N_BIT]; // RL20
    options.wd_window_sel = wd_opt_reg[rsc_pkg::WD_WINDOW_LO_BIT +: 2]; // RL22
    unique case (wd_opt_reg[rsc_pkg::WD_PERIOD_LO_BIT +: 2]) // RL21
      2'h0: options.wd_period = rsc_pkg::WD_PERIOD_0;
      2'h1: options.wd_period = rsc_pkg::WD_PERIOD_1;
      2'h2: options.wd_period = rsc_pkg::WD_PERIOD_2;
      2'h3: options.wd_period = rsc_pkg::WD_PERIOD_3;
    endcase
  end

  // Protect unlock and software reset request
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      unlock_reg <= 1'b0;
      soft_req_reg <= 1'b0;
    end
    else if (state_reg != rsc_pkg::RSC_RUN)
    begin
      unlock_reg <= 1'b0;
      soft_req_reg <= 1'b0;
    end
    else
    begin
      if (wr && addr == rsc_pkg::PROTECT_CONTROL_REG_ADDR)
        unlock_reg <= wdata[rsc_pkg::UNLOCK_BIT]; // RL15
      if (mode_wr && wdata[rsc_pkg::SOFT_REQ_BIT])
        soft_req_reg <= 1'b1; // RL2
    end
  end

  // Watchdog underflow request, held until the sequencer leaves run
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wd_req_reg <= 1'b0;
    else if (watchdog_underflow)
      wd_req_reg <= 1'b1; // RL3
    else if (state_reg != rsc_pkg::RSC_RUN)
      wd_req_reg <= 1'b0;
  end

  // Remembers a power or monitor0 reset; its release waits for the slow count
  always_ff @(posedge clk)
  begin
    if (!nrst)
      por_pending_reg <= 1'b0;
    else if (power_src)
      por_pending_reg <= 1'b1; // RL9
    else if (state_reg == rsc_pkg::RSC_SEQ)
      por_pending_reg <= 1'b0;
  end

  // Sequencer state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rsc_pkg::RSC_HOLD:
        if (!any_src && por_pending_reg)
          state_next = rsc_pkg::RSC_POR_WAIT; // RL9
        else if (!any_src)
          state_next = rsc_pkg::RSC_SEQ;
      rsc_pkg::RSC_POR_WAIT:
        if (pin_low || power_src)
          state_next = rsc_pkg::RSC_HOLD;
        else if (por_cnt_reg == rsc_pkg::POR_COUNT)
          state_next = rsc_pkg::RSC_SEQ; // RL9
      rsc_pkg::RSC_SEQ:
        if (pin_low || power_src)
          state_next = rsc_pkg::RSC_HOLD;
        else if (seq_cnt_reg == 3'(rsc_pkg::SEQ_CYCLES - 1))
          state_next = rsc_pkg::RSC_RUN;
      rsc_pkg::RSC_RUN:
        if (any_src)
          state_next = rsc_pkg::RSC_HOLD; // RL1
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_reg <= rsc_pkg::RSC_HOLD;
    else
      state_reg <= state_next;
  end

  // Slow clock counter after supply crosses threshold
  always_ff @(posedge clk)
  begin
    if (!nrst)
      por_cnt_reg <= 6'h0;
    else if (state_reg != rsc_pkg::RSC_POR_WAIT)
      por_cnt_reg <= 6'h0;
    else if (osc_edge && por_cnt_reg != rsc_pkg::POR_COUNT)
      por_cnt_reg <= por_cnt_reg + 6'h1; // RL9
  end

  // Common reset sequence length counter
  always_ff @(posedge clk)
  begin
    if (!nrst)
      seq_cnt_reg <= 3'h0;
    else if (state_reg != rsc_pkg::RSC_SEQ)
      seq_cnt_reg <= 3'h0;
    else
      seq_cnt_reg <= seq_cnt_reg + 3'h1;
  end

  // Cause flags survive the internal reset; nrst clears all of them, power_src also clears the cold flag
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cold_warm_reg <= 1'b0;
      pin_seen_reg <= 1'b0;
      soft_seen_reg <= 1'b0;
      wd_seen_reg <= 1'b0;
    end
    else
    begin
      if (power_src)
        cold_warm_reg <= 1'b0; // RL11
      else if (wr && addr == rsc_pkg::RESET_CAUSE_FLAGS_ADDR
               && wdata[rsc_pkg::COLD_WARM_BIT])
        cold_warm_reg <= 1'b1; // RL12
      if (pin_low)
        pin_seen_reg <= 1'b1; // RL23
      if (soft_req_reg)
        soft_seen_reg <= 1'b1; // RL23
      if (wd_req_reg)
        wd_seen_reg <= 1'b1; // RL23
    end
  end

  // CPU clock select: forced to undivided slow oscillator during reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
      clk_sel_reg <= rsc_pkg::CLK_LOCO_UNDIV;
    else if (state_reg != rsc_pkg::RSC_RUN)
      clk_sel_reg <= rsc_pkg::CLK_LOCO_UNDIV; // RL5
    else if (wr && addr == rsc_pkg::CLOCK_SEL_ADDR)
      clk_sel_reg <= wdata[1:0];
  end

  // Outputs
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      internal_reset_n <= 1'b0;
      fetch_reset_vector <= 1'b0;
    end
    else
    begin
      internal_reset_n <= (state_next == rsc_pkg::RSC_RUN); // RL24
      fetch_reset_vector <= (state_reg == rsc_pkg::RSC_SEQ)
        && (state_next == rsc_pkg::RSC_RUN); // RL4
    end
  end

  assign cpu_clock_sel = clk_sel_reg;
  // RAM has no reset path; writes are blocked while reset is active
  assign ram_write_block = !internal_reset_n; // RL6

  // Register read port; cold flag read as stored even when monitor off (RL13)
  // RL13
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd)
    begin
      unique case (addr)
        rsc_pkg::RESET_CAUSE_FLAGS_ADDR:
          rdata <= {4'h0, wd_seen_reg, soft_seen_reg, pin_seen_reg, cold_warm_reg}; // RL14
        rsc_pkg::BOOT_OPTION_BYTE_ADDR: rdata <= boot_opt_reg;
        rsc_pkg::WATCHDOG_OPTION_BYTE_ADDR: rdata <= wd_opt_reg;
        rsc_pkg::PROTECT_CONTROL_REG_ADDR: rdata <= {6'h00, unlock_reg, 1'b0};
        rsc_pkg::CLOCK_SEL_ADDR: rdata <= {6'h00, clk_sel_reg};
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule : rsc_reset_source_controller
